//--- qsfm_pkg.sv
// Shared constants and types for the quad switch fault manager.
// Assumes a 200 MHz system clock and an APB master with 32-bit data.
`default_nettype none

package qsfm_pkg;

    // System clock rate in kHz; timing counts derive from it.
    localparam int CLK_KHZ = 200000;

    // Autoretry period in microseconds; the cycle count follows from it.
    localparam int RETRY_PERIOD_US = 1000;
    localparam int RETRY_CYCLES = RETRY_PERIOD_US * CLK_KHZ / 1000;

    // Most autoretry attempts allowed per channel.
    localparam logic [4:0] RETRY_LIMIT = 5'h10;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DIAG_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] RETRY_OFFSET = 8'h0C;

    // Reset values of the writable registers.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DIAG_RESET = 32'h0000_0000;

    // Control register field positions.
    localparam int CTRL_ON_LSB = 0;
    localparam int CTRL_DIRDIS_LSB = 4;
    localparam int CTRL_PWM_BIT = 8;
    localparam int CTRL_OVOFF_BIT = 9;
    localparam int CTRL_OCSET_LSB = 10;

    // Diagnostic configuration field positions.
    localparam int DIAG_OSOFF_LSB = 0;
    localparam int DIAG_OLOFF_LSB = 4;
    localparam int DIAG_LED_LSB = 8;

    // Status register field positions.
    localparam int ST_OT_LSB = 0;
    localparam int ST_OC_LSB = 4;
    localparam int ST_SC_LSB = 8;
    localparam int ST_OS_LSB = 12;
    localparam int ST_OLOFF_LSB = 16;
    localparam int ST_OPEN_LOAD_ON_FLAG_LSB = 20;
    localparam int ST_OV_BIT = 24;
    localparam int ST_UV_BIT = 25;

    // Overcurrent detection settings handed to the analog comparators.
    typedef struct packed {
        logic coolingActive;
        logic [1:0] coolingSlopeSelect;
        logic [1:0] steadyCurrentLevelSel;
        logic highStepRemove;
        logic [1:0] currentSlopeSelect;
        logic lampProfile;
    } qsfm_oc_setting_type;

    localparam int OCSET_W = $bits(qsfm_oc_setting_type);

endpackage : qsfm_pkg

`default_nettype wire

//--- qsfm_fault_manager.sv
// Fault protection and diagnostic manager for a four channel switch.
// Assumes analog comparators drive the raw fault inputs asynchronously
// and an APB master reaches the registers on the same clock.
//
// Operation
// - Overheat while on latches output off, pin low
// - OT/OC release needs fault gone plus retry/toggle/reset
// - Overheat while off holds pin low, no latch
// - Overtemperature flag set, cleared by read
// - Four current steps, profile, slope, step-remove settings
// - Steady level defaults, two-bit select of alternatives
// - Overcurrent latches output off, pin low, flag
// - Lamp cooling shapes first step under PWM
// - Severe short latches off, pin low, flag
// - Severe short released only by toggle, mode change, supply fail or reset
// - Overvoltage shuts all outputs, pin low, flag
// - Protect-off keeps warning flag, blocks turn-on
// - Undervoltage turns outputs off, flag, pin low
// - Retry request is OC or OT or UV
// - Retry after one period, at most sixteen
// - Mode transitions clear retry counters
// - Retry restores default overcurrent settings
// - Off-state supply short sets flags, drives pin
// - Off-state open load flag, per-channel disable
// - On-state open load flags only, output stays
// - Fault clear follows direct input or on bit
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none

module qsfm_fault_manager
    import qsfm_pkg::*;
#(
    parameter int RETRY_CYCLES_P = RETRY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] overTemp,
    input wire logic [3:0] overCurrent,
    input wire logic [3:0] severeShort,
    input wire logic [3:0] shortToSupply,
    input wire logic [3:0] openLoadOff,
    input wire logic [3:0] openLoadOn,
    input wire logic [3:0] gateOff,
    input wire logic [3:0] directIn,
    input wire logic overVoltage,
    input wire logic underVoltage,
    input wire logic failSafe,
    input wire logic logicSupplyFail,
    output logic [3:0] outputOn,
    output logic fault_status_pin_n,
    output logic [3:0] led_open_load_select,
    output qsfm_oc_setting_type [3:0] ocSetting
);

    // Matches a byte address against a register offset.
    function automatic logic addrIs(input logic [31:0] a,
                                    input logic [7:0] off);
        addrIs = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : addrIs

    // Three-stage synchronisers for every asynchronous input.
    // Comparator outputs change at any time, hence three stages.
    logic [35:0] rawIn;
    logic [35:0] syncA_reg;
    logic [35:0] syncB_reg;
    logic [35:0] syncC_reg;
    logic [35:0] filt_reg;
    logic [35:0] filt_next;

    // The bit order of this bundle fixes the slices taken further down.
    // Keep both lists in step whenever an input is added.
    assign rawIn = {logicSupplyFail, failSafe, underVoltage, overVoltage,
                    directIn, gateOff, openLoadOn, openLoadOff,
                    shortToSupply, severeShort, overCurrent, overTemp};

    // A level change counts only once stages two and three agree.
    // A one-cycle glitch on a comparator is thus never acted upon.
    // The price is a fixed latency of four edges on every fault.
    assign filt_next = (syncB_reg & syncC_reg) |
                       (filt_reg & (syncB_reg | syncC_reg));

    // Synchroniser chain and agreement filter.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            syncC_reg <= '0;
            filt_reg <= '0;
        end else begin
            syncA_reg <= rawIn;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            filt_reg <= filt_next;
        end
    end

    // Filtered conditions, named by meaning.
    // Gate-off tells that the channel's gate has really discharged.
    wire [3:0] ot = filt_reg[3:0];
    wire [3:0] oc = filt_reg[7:4];
    wire [3:0] sc = filt_reg[11:8];
    wire [3:0] os = filt_reg[15:12];
    wire [3:0] olOff = filt_reg[19:16];
    wire [3:0] open_load_on_flag = filt_reg[23:20];
    wire [3:0] gOff = filt_reg[27:24];
    wire [3:0] din = filt_reg[31:28];
    wire ov = filt_reg[32];
    wire uv = filt_reg[33];
    wire fsMode = filt_reg[34];
    wire supFail = filt_reg[35];

    // Software-visible configuration and flag state.
    logic [31:0] ctrl_reg;
    logic [31:0] diag_reg;
    logic [25:0] status_reg;
    logic [25:0] status_next;
    logic fsPrev_reg;
    logic [3:0] fcPrev_reg;

    // Fault latches and the default-settings hold after a retry.
    logic [3:0] otLatch_reg;
    logic [3:0] ocLatch_reg;
    logic [3:0] scLatch_reg;
    logic [3:0] otLatch_next;
    logic [3:0] ocLatch_next;
    logic [3:0] scLatch_next;
    logic [3:0] dfltHold_reg;
    logic [3:0] dfltHold_next;

    // Configuration fields.
    wire [3:0] onBit = ctrl_reg[CTRL_ON_LSB +: 4];
    wire [3:0] dirDis = ctrl_reg[CTRL_DIRDIS_LSB +: 4];
    wire pwmEn = ctrl_reg[CTRL_PWM_BIT];
    wire ovOff = ctrl_reg[CTRL_OVOFF_BIT];
    // The whole detector setting, cooling enable on top, sits in CTRL.
    wire [OCSET_W-1:0] ocCfg = ctrl_reg[CTRL_OCSET_LSB +: OCSET_W];
    wire [3:0] osDis = diag_reg[DIAG_OSOFF_LSB +: 4];
    wire [3:0] olDis = diag_reg[DIAG_OLOFF_LSB +: 4];

    // Fault clear control per channel.
    // With PWM on, only the serial on bit can start a release.
    wire [3:0] faultCtl = (din & ~dirDis & {4{~pwmEn}}) | onBit;
    wire [3:0] fcRise = faultCtl & ~fcPrev_reg;

    // Fail-safe hands the outputs to the direct inputs.
    wire [3:0] hsCmd = fsMode ? din : faultCtl;

    // Any mode change or logic supply failure wipes latched faults.
    // fsPrev_reg starts low, so leaving reset in fail-safe counts too.
    wire modeChange = fsMode ^ fsPrev_reg;
    wire clearAll = modeChange | supFail;

    // Autoretry requests and firing strobes from the channel timers.
    // A retry request alone does not arm a timer: the channel must
    // also be latched off by heat or overcurrent.
    wire [3:0] otFlag = status_reg[ST_OT_LSB +: 4];
    wire [3:0] ocFlag = status_reg[ST_OC_LSB +: 4];
    wire uvFlag = status_reg[ST_UV_BIT];
    wire [3:0] retryReq = ocFlag | otFlag | {4{uvFlag}};
    wire [3:0] latchedOff = otLatch_reg | ocLatch_reg;
    wire faultMode = |{otLatch_reg, ocLatch_reg, scLatch_reg, uv, ov};
    wire [3:0] retryFire;
    wire [19:0] retryCountBus;

    // Overtemperature latches only when the channel is commanded on.
    // Release needs the heat gone and a retry or a clear toggle.
    assign otLatch_next = clearAll ? 4'h0 :
        (otLatch_reg & ~(~ot & (retryFire | fcRise))) |
        (ot & hsCmd);

    // Overcurrent latches only while the output is on; release is the same.
    assign ocLatch_next = clearAll ? 4'h0 :
        (ocLatch_reg & ~(~oc & (retryFire | fcRise))) |
        (oc & outputOn);

    // A severe short is never released by a retry.
    assign scLatch_next = clearAll ? 4'h0 :
        (scLatch_reg & ~(~sc & fcRise)) |
        (sc & hsCmd);

    // After a retry the detector runs on defaults until a real turn-on.
    assign dfltHold_next = clearAll ? 4'h0 :
        (dfltHold_reg & ~fcRise) | retryFire;

    // Output enable: blocked by latches, undervoltage and overvoltage.
    // With protection off, overvoltage only stops new turn-ons.
    // Undervoltage is not latched; the output returns with the supply.
    wire [3:0] ovGate = !ov ? 4'hF : (ovOff ? outputOn : 4'h0);
    wire [3:0] outputOn_next = hsCmd & ~otLatch_next & ~ocLatch_next &
        ~scLatch_next & {4{~uv}} & ovGate;

    // Flags that hardware sets; off-state checks wait for the gate.
    // Heat sets its flag whether or not the channel is commanded on.
    wire [3:0] osSet = os & gOff & ~hsCmd & ~osDis;
    wire [3:0] olOffSet = (olOff & gOff & ~hsCmd & ~olDis) | osSet;
    wire [3:0] olOnSet = open_load_on_flag & outputOn;
    wire [25:0] statusSet = {uv, ov, olOnSet, olOffSet, osSet,
        sc & hsCmd, oc & outputOn, ot};

    // APB decode.
    // Only the first 256 bytes are decoded; any higher address misses.
    wire setupPh = psel & ~penable;
    wire accessDone = psel & penable & pready;
    wire hitCtrl = addrIs(paddr, CTRL_OFFSET);
    wire hitDiag = addrIs(paddr, DIAG_OFFSET);
    wire hitStatus = addrIs(paddr, STATUS_OFFSET);
    wire hitRetry = addrIs(paddr, RETRY_OFFSET);
    wire mapped = hitCtrl | hitDiag | hitStatus | hitRetry;
    wire [31:0] readMux =
        hitCtrl ? ctrl_reg :
        hitDiag ? diag_reg :
        hitStatus ? {6'h00, status_reg} :
        hitRetry ? {12'h000, retryCountBus} : 32'h0000_0000;

    // Only bits already copied into prdata are cleared, and a set in
    // the same cycle still wins, so no event is lost.
    wire [25:0] readClr = (accessDone & ~pwrite & hitStatus) ?
        prdata[25:0] : 26'h0000000;
    assign status_next = clearAll ? statusSet :
        (status_reg & ~readClr) | statusSet;

    // Fault pin: latched faults, live heat while off, undervoltage, overvoltage with protection on,
    // and off-state diagnostics; on-state open load stays silent.
    wire pinFault = |{otLatch_next, ocLatch_next, scLatch_next,
        ot & ~hsCmd, osSet, olOffSet, uv, ov & ~ovOff};

    // Per-channel autoretry timers and attempt counters.
    // Each channel keeps its own timer, so retries never wait on
    // another channel's fault.
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_retry
            logic [31:0] tmr_reg;
            logic [4:0] cnt_reg;
            // Runs only in fault mode while the channel is latched off
            // and attempts remain.
            wire armed = faultMode & retryReq[ch] & latchedOff[ch] &
                (cnt_reg < RETRY_LIMIT);
            assign retryFire[ch] = armed &
                (tmr_reg == 32'(RETRY_CYCLES_P - 1));
            assign retryCountBus[ch*5 +: 5] = cnt_reg;

            // Counter clears on any mode change.
            always_ff @(posedge sys_clk) begin
                if (!rst_n || modeChange || supFail) begin
                    tmr_reg <= '0;
                    cnt_reg <= '0;
                end else if (!armed || retryFire[ch]) begin
                    tmr_reg <= '0;
                    cnt_reg <= cnt_reg + {4'h0, retryFire[ch]};
                end else begin
                    tmr_reg <= tmr_reg + 32'h0000_0001;
                end
            end

            // Settings per channel; cooling needs normal mode and PWM.
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    ocSetting[ch] <= '0;
                end else if (dfltHold_next[ch]) begin
                    ocSetting[ch] <= '0;
                end else begin
                    // Cooling needs its enable, the lamp profile and PWM.
                    ocSetting[ch] <= {ocCfg[OCSET_W-1] & ocCfg[0] &
                        pwmEn & ~fsMode,
                        ocCfg[OCSET_W-2:0]};
                end
            end
        end
    endgenerate

    // APB slave: data is loaded in setup, ready in the access cycle.
    // Read data is frozen at setup, so a flag that sets during the
    // access shows up on the next read instead of being cleared.
    // Limitation: no wait states are ever inserted.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPh) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= ~mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration writes; fail-safe holds everything at defaults.
    // Bits above bit 19 of CTRL and bit 11 of DIAG are dropped so they read back 0.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || fsMode || supFail) begin
            ctrl_reg <= CTRL_RESET;
            diag_reg <= DIAG_RESET;
        end else if (accessDone && pwrite) begin
            if (hitCtrl) begin
                ctrl_reg <= {12'h000, pwdata[19:0]};
            end
            if (hitDiag) begin
                diag_reg <= {20'h00000, pwdata[11:0]};
            end
        end
    end

    // Fault state, flags, output drive and fault pin.
    // The pin is registered so decode glitches never reach the board.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_reg <= '0;
            otLatch_reg <= 4'h0;
            ocLatch_reg <= 4'h0;
            scLatch_reg <= 4'h0;
            dfltHold_reg <= 4'h0;
            fcPrev_reg <= 4'h0;
            fsPrev_reg <= 1'b0;
            outputOn <= 4'h0;
            fault_status_pin_n <= 1'b1;
            led_open_load_select <= 4'h0;
        end else begin
            status_reg <= status_next;
            otLatch_reg <= otLatch_next;
            ocLatch_reg <= ocLatch_next;
            scLatch_reg <= scLatch_next;
            dfltHold_reg <= dfltHold_next;
            fcPrev_reg <= faultCtl;
            fsPrev_reg <= fsMode;
            outputOn <= outputOn_next;
            fault_status_pin_n <= ~pinFault;
            led_open_load_select <= diag_reg[DIAG_LED_LSB +: 4];
        end
    end

endmodule : qsfm_fault_manager

`default_nettype wire

//--- qsfm_checker.sv
// Checker for the fault manager, bound to the top module's ports.
// Assumes raw fault inputs settle at the outputs within 8 cycles.
`default_nettype none
module qsfm_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] overTemp,
    input wire logic [3:0] overCurrent,
    input wire logic [3:0] severeShort,
    input wire logic overVoltage,
    input wire logic underVoltage,
    input wire logic [3:0] outputOn,
    input wire logic fault_status_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Eight held cycles cover the four stage filter with margin.
    // With protection off outputs may stay on, but none may turn on.
    property p_ov;
        overVoltage [*8] |-> (outputOn & ~$past(outputOn)) == 4'h0;
    endproperty
    a_ov: assert property (p_ov)
        else $error("output on during overvoltage");
    property p_uv; underVoltage [*8] |-> !fault_status_pin_n; endproperty
    a_uv: assert property (p_uv)
        else $error("pin high during undervoltage");
    property p_oc; overCurrent[0] [*8] |-> !outputOn[0]; endproperty
    a_oc: assert property (p_oc)
        else $error("channel 0 on during overcurrent");
    property p_sc; severeShort[1] [*8] |-> !outputOn[1]; endproperty
    a_sc: assert property (p_sc)
        else $error("channel 1 on during severe short");
    property p_ot; overTemp[2] [*8] |-> !fault_status_pin_n; endproperty
    a_ot: assert property (p_ot)
        else $error("pin high while channel 2 is hot");
    // The slave answers with no wait state and a one cycle pulse.
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy)
        else $error("no ready after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_err;
        pready |-> pslverr == !(paddr inside {32'h0, 32'h4, 32'h8, 32'hC});
    endproperty
    a_err: assert property (p_err)
        else $error("error flag does not match the address map");
    cover property (pready && pslverr);
    cover property ($fell(fault_status_pin_n));
    cover property ($rose(outputOn[1]));
endmodule : qsfm_checker

bind qsfm_fault_manager qsfm_checker qsfm_checker_i (.sys_clk, .rst_n,
    .psel, .penable, .paddr, .pready, .pslverr, .overTemp, .overCurrent,
    .severeShort, .overVoltage, .underVoltage, .outputOn,
    .fault_status_pin_n);
`default_nettype wire

//--- qsfm_mcu_model.sv
// Microcontroller model: an APB master for the fault registers.
// Assumes the slave shares sys_clk and answers through pready.
`default_nettype none
module qsfm_mcu_model (
    input wire logic sys_clk,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [31:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero; wake/reset is taken as held high.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // One transfer; reading status is what clears its flags.
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Released lines show the inverse so stale values never match.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : qsfm_mcu_model
`default_nettype wire

//--- qsfm_fault_manager_bench.sv
// Self-checking bench for the fault manager.
// Assumes the package, the model and the bound checker are compiled.
`default_nettype none
module qsfm_fault_manager_bench;
    import qsfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_CTRL = {24'h0, CTRL_OFFSET};
    localparam logic [31:0] A_DIAG = {24'h0, DIAG_OFFSET};
    localparam logic [31:0] A_STAT = {24'h0, STATUS_OFFSET};
    localparam logic [31:0] A_RETRY = {24'h0, RETRY_OFFSET};
    localparam logic [31:0] LOOP_ST [4] = '{32'h4, 32'h0100_0000,
        32'h0200_0000, 32'h0020_0000};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pinN;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] overTemp = 4'h0, overCurrent = 4'h0, severeShort = 4'h0;
    logic [3:0] shortToSupply = 4'h0, openLoadOff = 4'h0;
    logic [3:0] openLoadOn = 4'h0, gateOff = 4'h0, directIn = 4'h0;
    logic [3:0] outputOn, ledSel;
    logic overVoltage = 1'b0, underVoltage = 1'b0;
    logic failSafe = 1'b0, logicSupplyFail = 1'b0;
    qsfm_oc_setting_type [3:0] ocSetting;
    int nFail = 0;
    int testsRun = 0;
    // Short retry period keeps the run brief.
    qsfm_fault_manager #(.RETRY_CYCLES_P(20)) qsfm_fault_manager_i (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .overTemp, .overCurrent, .severeShort,
        .shortToSupply, .openLoadOff, .openLoadOn, .gateOff, .directIn,
        .overVoltage, .underVoltage, .failSafe,
        .logicSupplyFail, .outputOn, .fault_status_pin_n(pinN),
        .led_open_load_select(ledSel), .ocSetting);
    qsfm_mcu_model qsfm_mcu_model_i (.sys_clk, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Output state compare: channel enables and the fault pin.
    task automatic st(input logic [3:0] on, input logic pin);
        chk({28'h0, outputOn}, {28'h0, on});
        chk({31'h0, pinN}, {31'h0, pin});
    endtask : st
    task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                      input logic err);
        logic [31:0] d;
        logic e;
        qsfm_mcu_model_i.xfer(1'b0, a, 32'h0, d, e);
        chk(d, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        qsfm_mcu_model_i.xfer(1'b1, a, v, d, e);
    endtask : wr
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    task automatic summarize();
        $display("mismatches %0d checks %0d", nFail, testsRun);
        if (nFail == 0 && testsRun > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // A hang counts as a failure.
    initial begin
        wt(4000);
        nFail++;
        summarize();
    end
    initial begin
        wt(10);
        rst_n <= 1'b1;
        wt(4);
        st(4'h0, 1'b1);
        rd(A_CTRL, CTRL_RESET, 1'b0);
        rd(A_DIAG, DIAG_RESET, 1'b0);
        rd(32'h10, 32'h0, 1'b1);
        wr(A_CTRL, 32'h0000_1C01);
        wt(4);
        chk({31'h0, ocSetting[0].lampProfile}, 32'h1);
        overCurrent <= 4'h1;
        wt(8);
        st(4'h0, 1'b0);
        overCurrent <= 4'h0;
        wt(40);
        chk({28'h0, outputOn}, 32'h1);
        chk({23'h0, ocSetting[0]}, 32'h0);
        rd(A_RETRY, 32'h1, 1'b0);
        rd(A_STAT, 32'h10, 1'b0);
        rd(A_STAT, 32'h0, 1'b0);
        wr(A_CTRL, 32'h2);
        severeShort <= 4'h2;
        wt(8);
        st(4'h0, 1'b0);
        severeShort <= 4'h0;
        wt(60);
        st(4'h0, 1'b0);
        wr(A_CTRL, 32'h0);
        wr(A_CTRL, 32'h2);
        wt(4);
        st(4'h2, 1'b1);
        rd(A_STAT, 32'h200, 1'b0);
        // Hot idle channel, overvoltage, undervoltage, open load on.
        for (int i = 0; i < 4; i++) begin
            overTemp <= {1'b0, i == 0, 2'b00};
            overVoltage <= (i == 1);
            underVoltage <= (i == 2);
            openLoadOn <= {2'b00, i == 3, 1'b0};
            wt(8);
            st((i == 1 || i == 2) ? 4'h0 : 4'h2, i == 3);
            overTemp <= 4'h0;
            overVoltage <= 1'b0;
            underVoltage <= 1'b0;
            openLoadOn <= 4'h0;
            wt(8);
            st(4'h2, 1'b1);
            rd(A_STAT, LOOP_ST[i], 1'b0);
        end
        wr(A_DIAG, 32'h0000_0F00);
        rd(A_DIAG, 32'h0000_0F00, 1'b0);
        chk({28'h0, ledSel}, 32'hF);
        gateOff <= 4'h8;
        shortToSupply <= 4'h8;
        wt(8);
        st(4'h2, 1'b0);
        shortToSupply <= 4'h0;
        wt(8);
        st(4'h2, 1'b1);
        rd(A_STAT, 32'h0008_8000, 1'b0);
        openLoadOff <= 4'h8;
        wt(8);
        openLoadOff <= 4'h0;
        wt(8);
        rd(A_STAT, 32'h0008_0000, 1'b0);
        // With both detections off, channel 3 reports nothing.
        wr(A_DIAG, 32'h0000_0088);
        shortToSupply <= 4'h8;
        openLoadOff <= 4'h8;
        wt(8);
        st(4'h2, 1'b1);
        rd(A_STAT, 32'h0, 1'b0);
        directIn <= 4'h4;
        wt(8);
        st(4'h6, 1'b1);
        // Lamp cooling under PWM, then overvoltage with protection off.
        wr(A_CTRL, 32'h0004_C702);
        wt(2);
        chk({23'h0, ocSetting[1]}, 32'h131);
        overVoltage <= 1'b1;
        wt(8);
        wr(A_CTRL, 32'h0004_C703);
        wt(4);
        st(4'h2, 1'b1);
        overVoltage <= 1'b0;
        wt(8);
        st(4'h3, 1'b1);
        rd(A_STAT, 32'h0100_0000, 1'b0);
        // Fail-safe entry and exit wipe the retry counters.
        directIn <= 4'h0;
        shortToSupply <= 4'h0;
        openLoadOff <= 4'h0;
        failSafe <= 1'b1;
        wt(8);
        failSafe <= 1'b0;
        wt(8);
        rd(A_RETRY, 32'h0, 1'b0);
        // A logic supply failure releases a severe short latch.
        wr(A_CTRL, 32'h2);
        severeShort <= 4'h2;
        wt(8);
        st(4'h0, 1'b0);
        severeShort <= 4'h0;
        logicSupplyFail <= 1'b1;
        wt(8);
        logicSupplyFail <= 1'b0;
        wt(8);
        st(4'h0, 1'b1);
        rd(A_CTRL, CTRL_RESET, 1'b0);
        summarize();
    end
endmodule : qsfm_fault_manager_bench
`default_nettype wire
